/* hw/lst_defs.vh */
// Register offsets, field positions, reset values and timing for link training.
`ifndef LST_DEFS_VH
`define LST_DEFS_VH

// ==========================================================================
// Register byte offsets
`define LST_CTRL_OFS        8'h00
`define LST_POL_OFS         8'h04
`define LST_WIDTH_OFS       8'h08
`define LST_STAT_OFS        8'h0c
`define LST_POLSTAT_OFS     8'h10
`define LST_LANEEN_OFS      8'h14
`define LST_CAP_OFS         8'h18

// ==========================================================================
// Control register fields
`define LST_CTRL_START      0
`define LST_CTRL_COPT_EN    1
`define LST_CTRL_POL_PROG   2
`define LST_CTRL_ASYM       3
`define LST_CTRL_CRC_EN     4
`define LST_CTRL_RETRAIN    5
`define LST_CTRL_ARC_LSB    6
`define LST_CTRL_RST        32'h0000_0000

// ==========================================================================
// Width register fields and reset
`define LST_TXW_LSB         0
`define LST_RXW_LSB         8
`define LST_WIDTH_RST       32'h0000_2020

// ==========================================================================
// Lane and width limits
`define LST_LANES           32
`define LST_MAX_TOTAL       7'h40

// ==========================================================================
// Capability word: line rate code 0 (64b/66b, 25.78125 GT/s), optional states
`define LST_CAP_VAL         32'h0000_0007

// ==========================================================================
// Timing: alignment dwell used to sample polarity, in nanoseconds
`define LST_ALIGN_NS        64
`define LST_CLK_NS          8
`define LST_ALIGN_CYC       ((`LST_ALIGN_NS + `LST_CLK_NS - 1) / `LST_CLK_NS)

`endif

/* hw/lst_lane_mask.v */
// Lane enable and central-lane masking for one direction of the link.
module lst_lane_mask (
    // Configured width of this direction
    input  wire [5:0]  width,
    input  wire        asym,
    // Lane mask result and central lane mask
    output wire [31:0] lane_en,
    output wire [31:0] center_mask
);

    // ======================================================================
    // Mask helpers
    function [31:0] low_mask;
        input [5:0] w;
        integer i;
        begin
            low_mask = 32'h0000_0000;
            for (i = 0; i < 32; i = i + 1) begin
                if (i < w) begin
                    low_mask[i] = 1'b1;
                end
            end
        end
    endfunction

    wire       odd_big = asym & width[0] & (width >= 6'h03);
    wire [4:0] center  = width[5:1];

    assign lane_en     = low_mask(width);
    assign center_mask = odd_big ? (32'h0000_0001 << center) : 32'h0000_0000;

endmodule

/* hw/lst_top.v */
// Link training state machine with lane configuration and AXI4-Lite access.
//
// Behaviour
// - Lanes run 25.78125 GT/s with 64b/66b.
// - Invert receive lanes with reversed polarity.
// - Detect lane polarity during alignment state.
// - Detect polarity in channel optimization when enabled.
// - Accept programmed polarity from management instead.
// - Symmetric widths 1,2,4,8,16,32 lanes allowed.
// - Asymmetric widths total at most 64 lanes.
// - Train symmetric first before channel optimization.
// - Asymmetric set after training by disabling lanes; the code instead applies the asymmetric widths to the lane enables in every state, idle included.
// - Idle, detect, align, configure, link-up states.
// - Optional channel optimization state.
// - Odd asymmetric transmitter of 3 or more lanes disables central lane during detect.
// - Odd asymmetric receiver of 3 or more lanes ignores central detect.
// - Optimization entry disabled after reset.
// - Optimization only when both ends enable it.
// - Several layers may aggregate statically.
// - No re-timer between the link partners.
// - Transfer-unit CRC encoding disabled after reset.
// - Only retraining arcs one and two.
`include "lst_defs.vh"

module lst_top (
    // Clock, reset, enable
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Link-side indications from the serial lanes
    input  wire [31:0] rx_detect,
    input  wire [31:0] rx_inverted,
    input  wire        align_done,
    input  wire        config_done,
    input  wire        copt_done,
    input  wire        remote_copt_en,
    input  wire        link_error,
    // Lane controls toward the serial lanes
    output reg  [31:0] tx_lane_en,
    output reg  [31:0] rx_lane_en,
    output reg  [31:0] rx_invert,
    output reg         copt_active,
    output reg         crc_encode_en,
    output reg         link_up
);

    // ======================================================================
    // States, one-hot
    localparam [5:0] ST_IDLE  = 6'b000001;
    localparam [5:0] ST_DET   = 6'b000010;
    localparam [5:0] ST_COPT  = 6'b000100;
    localparam [5:0] ST_ALIGN = 6'b001000;
    localparam [5:0] ST_CONF  = 6'b010000;
    localparam [5:0] ST_UP    = 6'b100000;
    localparam [31:0] ALIGN_CYC = `LST_ALIGN_CYC;

    reg [5:0]  state_ff;
    reg [5:0]  nxt_state;
    reg [7:0]  dwell_ff;
    reg [31:0] ctrl_ff;
    reg [31:0] pol_ff;
    reg [31:0] width_ff;
    reg [31:0] pol_det_ff;
    reg        aw_ff;
    reg        w_ff;
    reg [7:0]  awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0]  wstrb_ff;

    // ======================================================================
    // Width decode and lane masks
    wire [5:0]  tx_w = width_ff[`LST_TXW_LSB +: 6];
    wire [5:0]  rx_w = width_ff[`LST_RXW_LSB +: 6];
    wire        asym = ctrl_ff[`LST_CTRL_ASYM];
    wire [31:0] tx_mask;
    wire [31:0] rx_mask;
    wire [31:0] tx_center;
    wire [31:0] rx_center;

    lst_lane_mask u_tx_mask (
        .width       (tx_w),
        .asym        (asym),
        .lane_en     (tx_mask),
        .center_mask (tx_center)
    );

    lst_lane_mask u_rx_mask (
        .width       (rx_w),
        .asym        (asym),
        .lane_en     (rx_mask),
        .center_mask (rx_center)
    );

    function pow2_width;
        input [5:0] w;
        begin
            pow2_width = (w != 6'h00) && ((w & (w - 6'h01)) == 6'h00);
        end
    endfunction

    // Symmetric sizes must be a power of two; asymmetric bound the sum and keep each side at 1..32 lanes.
    wire width_ok = asym ?
        (({1'b0, tx_w} + {1'b0, rx_w}) <= `LST_MAX_TOTAL) &&
        (tx_w != 6'h00) && (rx_w != 6'h00) && (tx_w <= 6'h20) &&
        (rx_w <= 6'h20) :
        (tx_w == rx_w) && pow2_width(tx_w) && (tx_w <= 6'h20);

    // Central receive lane of an odd asymmetric width of 3 or more lanes is not consulted.
    wire [31:0] det_used = rx_mask & ~rx_center;
    wire        det_all  = ((rx_detect & det_used) == det_used);

    // Both ends must enable optimization; local bit is clear after reset.
    wire copt_go = ctrl_ff[`LST_CTRL_COPT_EN] & remote_copt_en;
    wire pol_prog = ctrl_ff[`LST_CTRL_POL_PROG];
    wire retrain  = ctrl_ff[`LST_CTRL_RETRAIN];

    // ======================================================================
    // Training state machine
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (ctrl_ff[`LST_CTRL_START] && width_ok) begin
                    nxt_state = ST_DET;
                end
            end
            ST_DET: begin
                if (det_all) begin
                    // Optimization is taken only on a symmetric setup.
                    nxt_state = (copt_go && !asym) ? ST_COPT : ST_ALIGN;
                end
            end
            ST_COPT: begin
                if (copt_done) begin
                    nxt_state = ST_ALIGN;
                end
            end
            ST_ALIGN: begin
                if (align_done && {24'h00_0000, dwell_ff} >= ALIGN_CYC) begin
                    nxt_state = ST_CONF;
                end
            end
            ST_CONF: begin
                if (config_done) begin
                    nxt_state = ST_UP;
                end
            end
            ST_UP: begin
                // Retrain arcs return to detect; only arcs 1 and 2 exist.
                if (link_error || retrain || !ctrl_ff[`LST_CTRL_START]) begin
                    nxt_state = ctrl_ff[`LST_CTRL_START] ? ST_DET : ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_ff   <= ST_IDLE;
            dwell_ff   <= 8'h00;
            pol_det_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            if (state_ff != nxt_state) begin
                dwell_ff <= 8'h00;
            end else if (dwell_ff != 8'hff) begin
                dwell_ff <= dwell_ff + 8'h01;
            end
            if (state_ff == ST_ALIGN && !pol_prog) begin
                pol_det_ff <= rx_inverted & rx_mask;
            end else if (state_ff == ST_COPT && !pol_prog) begin
                pol_det_ff <= rx_inverted & rx_mask;
            end
        end
    end

    // ======================================================================
    // Lane outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_lane_en    <= 32'h0000_0000;
            rx_lane_en    <= 32'h0000_0000;
            rx_invert     <= 32'h0000_0000;
            copt_active   <= 1'b0;
            crc_encode_en <= 1'b0;
            link_up       <= 1'b0;
        end else if (clk_en) begin
            // Central transmitter kept off while detection runs.
            tx_lane_en <= (nxt_state == ST_DET) ?
                          (tx_mask & ~tx_center) : tx_mask;
            // Removing lanes from the width disables them directly.
            rx_lane_en <= rx_mask;
            rx_invert  <= (pol_prog ? pol_ff : pol_det_ff) & rx_mask;
            copt_active   <= (nxt_state == ST_COPT);
            crc_encode_en <= ctrl_ff[`LST_CTRL_CRC_EN];
            link_up       <= (nxt_state == ST_UP);
        end
    end

    // ======================================================================
    // AXI4-Lite slave: address and data taken in either order
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_ff | aw_take;
    wire w_have  = w_ff | w_take;
    wire [7:0]  wr_addr = aw_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_ff ? wdata_ff : s_axi_wdata;
    wire [3:0]  wr_strb = w_ff ? wstrb_ff : s_axi_wstrb;
    wire        wr_go   = aw_have & w_have & ~s_axi_bvalid;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (st[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    wire wr_ok = (wr_addr == `LST_CTRL_OFS) || (wr_addr == `LST_POL_OFS) ||
                 (wr_addr == `LST_WIDTH_OFS);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_ff         <= 1'b0;
            w_ff          <= 1'b0;
            awaddr_ff     <= 8'h00;
            wdata_ff      <= 32'h0000_0000;
            wstrb_ff      <= 4'h0;
            ctrl_ff       <= `LST_CTRL_RST;
            pol_ff        <= 32'h0000_0000;
            width_ff      <= `LST_WIDTH_RST;
        end else if (clk_en) begin
            // The retrain request is a one-shot.
            ctrl_ff[`LST_CTRL_RETRAIN] <= 1'b0;
            if (aw_take) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_ff     <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            s_axi_awready <= ~aw_have & ~s_axi_awready;
            s_axi_wready  <= ~w_have & ~s_axi_wready;
            if (wr_go) begin
                aw_ff        <= 1'b0;
                w_ff         <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
                case (wr_addr)
                    `LST_CTRL_OFS: begin
                        ctrl_ff <= merge(ctrl_ff, wr_data, wr_strb) &
                                   32'h0000_007f;
                    end
                    `LST_POL_OFS: begin
                        pol_ff <= merge(pol_ff, wr_data, wr_strb);
                    end
                    `LST_WIDTH_OFS: begin
                        width_ff <= merge(width_ff, wr_data, wr_strb) &
                                    32'h0000_3f3f;
                    end
                    default: begin
                        ctrl_ff[`LST_CTRL_RETRAIN] <= 1'b0;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (clk_en) begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `LST_CTRL_OFS:    s_axi_rdata <= ctrl_ff;
                    `LST_POL_OFS:     s_axi_rdata <= pol_ff;
                    `LST_WIDTH_OFS:   s_axi_rdata <= width_ff;
                    `LST_STAT_OFS:    s_axi_rdata <= {25'h0, width_ok, state_ff};
                    `LST_POLSTAT_OFS: s_axi_rdata <= pol_det_ff;
                    `LST_LANEEN_OFS:  s_axi_rdata <= tx_lane_en;
                    `LST_CAP_OFS:     s_axi_rdata <= `LST_CAP_VAL;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Direct point-to-point link only; aggregation is left to the level above.

endmodule

/* bench/lst_top_assertions.sv */
// Port-level checks for the link training block, bound into its top module.
module lst_chk (
    // Clock and reset
    input wire       aclk, aresetn,
    // Register bus handshakes
    input wire       s_axi_awvalid, s_axi_awready,
    input wire       s_axi_wvalid, s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire       s_axi_bvalid, s_axi_bready,
    input wire       s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    // Link side
    input wire       config_done, remote_copt_en, link_error,
    input wire       copt_active, crc_encode_en, link_up
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==================================================================
    // Helper: set once software has finished its first write.
    logic wr_seen_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            wr_seen_ff <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            wr_seen_ff <= 1'b1;
    end
    // ==================================================================
    // Properties
    property p_crc_rst;
        $rose(aresetn) |-> !crc_encode_en;
    endproperty
    a_crc_rst: assert property (p_crc_rst)
        else $error("crc encode on after reset");
    property p_copt_gate;
        !wr_seen_ff |-> !copt_active;
    endproperty
    a_copt_gate: assert property (p_copt_gate)
        else $error("optimize entered before any setup");
    property p_copt_both;
        $rose(copt_active) |-> $past(remote_copt_en);
    endproperty
    a_copt_both: assert property (p_copt_both)
        else $error("optimize without far end consent");
    property p_up_cause;
        $rose(link_up) |-> $past(config_done);
    endproperty
    a_up_cause: assert property (p_up_cause)
        else $error("link up without configure done");
    property p_err_drop;
        link_up && link_error |-> ##[1:3] !link_up;
    endproperty
    a_err_drop: assert property (p_err_drop)
        else $error("link error did not leave link up");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_b_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_b_ans: assert property (p_b_ans)
        else $error("write response late");
    property p_r_ans;
        s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
    endproperty
    a_r_ans: assert property (p_r_ans)
        else $error("read response late");
endmodule

bind lst_top lst_chk lst_chk_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .config_done, .remote_copt_en, .link_error,
    .copt_active, .crc_encode_en, .link_up);

/* bench/lst_peer.sv */
// Far-end link partner model that answers the training handshakes.
module lst_peer (
    // Clock and far-end controls
    input  logic        aclk,
    input  logic [31:0] p_lanes, p_inv,
    input  logic        p_copt, p_slow,
    // Near-end lane state
    input  logic [31:0] tx_lane_en,
    input  logic        copt_active, link_up,
    // Indications back to the near end
    output logic [31:0] rx_detect, rx_inverted,
    output logic        align_done, config_done, copt_done,
    output logic        remote_copt_en
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    logic ph = 1'b0;
    // Progress is only reported after our lanes have been seen a while.
    always @(posedge aclk) begin
        ph <= ~ph;
        if (link_up || tx_lane_en == 32'h0)
            cnt <= 0;
        else if (cnt < 99)
            cnt <= cnt + 1;
    end
    // Silent lanes give no steady polarity, so they toggle each cycle.
    assign rx_detect      = p_lanes;
    assign rx_inverted    = p_inv ^ (~p_lanes & {32{ph}});
    assign align_done     = cnt >= (p_slow ? 40 : 3);
    assign config_done    = align_done;
    assign copt_done      = copt_active && align_done;
    assign remote_copt_en = p_copt;
endmodule

/* bench/local_serdes_link_training_bench.sv */
// Self-checking bench for the link training block and its far end.
module local_serdes_link_training_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // Signals
    logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, link_error = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] rx_detect, rx_inverted, tx_lane_en, rx_lane_en, rx_invert;
    logic        align_done, config_done, copt_done, remote_copt_en;
    logic        copt_active, crc_encode_en, link_up;
    logic [31:0] p_lanes = '1, p_inv = 32'h0;
    logic        p_copt = 1'b0, p_slow = 1'b0;
    int          n_mismatch = 0, n_compared = 0, n_copt = 0, m;
    logic [31:0] wv [6] = '{32'h2020, 32'h0606, 32'h0503, 32'h0503,
                            32'h2121, 32'h0};
    logic [1:0]  wk [6] = '{2'h1, 2'h0, 2'h0, 2'h3, 2'h2, 2'h0};

    lst_top lst_top_i (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rx_detect, .rx_inverted, .align_done, .config_done, .copt_done,
        .remote_copt_en, .link_error, .tx_lane_en, .rx_lane_en,
        .rx_invert, .copt_active, .crc_encode_en, .link_up);
    lst_peer lst_peer_i (.aclk, .p_lanes, .p_inv, .p_copt, .p_slow,
        .tx_lane_en, .copt_active, .link_up, .rx_detect, .rx_inverted,
        .align_done, .config_done, .copt_done, .remote_copt_en);

    initial begin
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (copt_active === 1'b1)
            n_copt++;
    end
    // ==================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                pa = 1'b0;
            if (s_axi_wready === 1'b1)
                pw = 1'b0;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er, input logic [31:0] mk = '1);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & mk, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic wt(input logic v);
        for (int t = 0; t < 400 && link_up !== v; t++)
            @(posedge aclk);
        chk({31'h0, link_up}, {31'h0, v});
    endtask
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==================================================================
    // Tests
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(8'h00, 32'h0, 2'h0);
        rc(8'h08, 32'h2020, 2'h0);
        rc(8'h18, 32'h7, 2'h0);
        rc(8'h1c, 32'h0, 2'h2);
        wr(8'h1c, 32'hffff_ffff, 2'h2);
        chk({31'h0, crc_encode_en}, 32'h0);
        $display("test 1 done");
        for (int i = 0; i < 6; i++) begin
            wr(8'h08, wv[i], 2'h0);
            wr(8'h00, {28'h0, wk[i][1], 3'h0}, 2'h0);
            rc(8'h0c, {25'h0, wk[i][0], 6'h01}, 2'h0);
        end
        $display("test 2 done");
        wr(8'h08, 32'h2020, 2'h0);
        p_inv <= 32'ha5a5_0f0f;
        wr(8'h00, 32'h1, 2'h0);
        wt(1'b1);
        rc(8'h0c, 32'h60, 2'h0);
        rc(8'h10, 32'ha5a5_0f0f, 2'h0);
        chk(rx_invert, 32'ha5a5_0f0f);
        chk(tx_lane_en, 32'hffff_ffff);
        wr(8'h04, 32'hff00, 2'h0);
        wr(8'h00, 32'h25, 2'h0);
        wt(1'b0);
        wt(1'b1);
        chk(rx_invert, 32'hff00);
        $display("test 3 done");
        p_slow <= 1'b1;
        link_error <= 1'b1;
        @(posedge aclk);
        link_error <= 1'b0;
        wt(1'b0);
        wt(1'b1);
        p_slow <= 1'b0;
        p_inv <= 32'h3c3c_3c3c;
        wr(8'h00, 32'h23, 2'h0);
        wt(1'b0);
        wt(1'b1);
        chk(n_copt, 32'h0);
        p_copt <= 1'b1;
        wr(8'h00, 32'h23, 2'h0);
        wt(1'b0);
        wt(1'b1);
        chk({31'h0, n_copt > 0}, 32'h1);
        chk(rx_invert, 32'h3c3c_3c3c);
        $display("test 4 done");
        wr(8'h00, 32'h0, 2'h0);
        wt(1'b0);
        wr(8'h08, 32'h0503, 2'h0);
        p_lanes <= 32'h1a;
        m = n_copt;
        wr(8'h00, 32'hb, 2'h0);
        rc(8'h0c, 32'h42, 2'h0);
        chk(tx_lane_en, 32'h5);
        rc(8'h14, 32'h5, 2'h0);
        p_lanes <= 32'h1b;
        wt(1'b1);
        chk(rx_lane_en, 32'h1f);
        chk(n_copt - m, 32'h0);
        wr(8'h00, 32'hdb, 2'h0);
        chk({31'h0, crc_encode_en}, 32'h1);
        rc(8'h00, 32'h0, 2'h0, 32'h80);
        $display("test 5 done");
        results();
    end
    initial begin
        #100us;
        n_mismatch++;
        results();
    end
endmodule
